/* rtl/dsa_pkg.sv */
// Constants, field positions and types for the dual sensor alarm monitor.
// Assumes a 20 MHz clock and a one-cycle sample strobe at the internal sample rate.
//
// How it works
// - Alarm flags of both channels appear as bits 9 and 8 of diagnostic status.
// - Configuration bits 2 to 0 steer the indicator onto one digital line.
// - Second source field bits 15:12 picks off, rates, accelerations or temperature.
// - First source field bits 11:8 uses the same source codes.
// - Bit 7 makes the second alarm dynamic when set, static when clear.
// - Bit 6 makes the first alarm dynamic when set, static when clear.
// - Bit 5 makes the second alarm trigger above threshold, else below.
// - Bit 4 makes the first alarm trigger above threshold, else below.
// - Bit 3 picks filtered data for both alarms, else unfiltered data.
// - Bit 2 enables the indicator; when clear no line is driven.
// - Bit 1 sets indicator active level, high when set, low when clear.
// - Bit 0 routes the indicator to line two when set, line one when clear.
// - Configuration register at 0x48, 16 bits, read-write, resets to zero.
// - Static mode compares the selected value with its threshold by polarity.
// - Dynamic mode compares change over the sample window with the threshold.
// - Eight-bit window count; values zero and one both mean one sample.
// - Thresholds use the same signed format as the selected sensor output.
package dsa_pkg;

   localparam int DATA_W = 16;
   localparam int WINDOW_W = 8;
   localparam int ADDR_W = 7;

   // Register offsets; the status offset is local to this block.
   localparam logic [6:0] OFS_FIRST_THRESHOLD = 7'h40;
   localparam logic [6:0] OFS_SECOND_THRESHOLD = 7'h42;
   localparam logic [6:0] OFS_FIRST_WINDOW = 7'h44;
   localparam logic [6:0] OFS_SECOND_WINDOW = 7'h46;
   localparam logic [6:0] OFS_CONFIGURATION = 7'h48;
   localparam logic [6:0] OFS_DIAGNOSTIC = 7'h3C;

   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
   localparam logic [7:0] WINDOW_RESET = 8'h00;
   localparam logic [7:0] MIN_WINDOW = 8'h01;
   localparam logic [7:0] FILL_MAX = 8'hFF;

   // Configuration field positions.
   localparam int SRC2_HI = 15;
   localparam int SRC2_LO = 12;
   localparam int SRC1_HI = 11;
   localparam int SRC1_LO = 8;
   localparam int DYN2_BIT = 7;
   localparam int DYN1_BIT = 6;
   localparam int POL2_BIT = 5;
   localparam int POL1_BIT = 4;
   localparam int FILT_BIT = 3;
   localparam int IND_EN_BIT = 2;
   localparam int IND_POL_BIT = 1;
   localparam int IND_SEL_BIT = 0;

   // Diagnostic status field positions.
   localparam int DIAG_FLAG1_BIT = 8;
   localparam int DIAG_FLAG2_BIT = 9;

   typedef enum logic [3:0] {
      SRC_OFF = 4'h0,
      SRC_RATE_X = 4'h1,
      SRC_RATE_Y = 4'h2,
      SRC_RATE_Z = 4'h3,
      SRC_ACCEL_X = 4'h4,
      SRC_ACCEL_Y = 4'h5,
      SRC_ACCEL_Z = 4'h6,
      SRC_TEMP = 4'hC
   } dsa_source_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EVAL = 2'b01
   } dsa_state_type;

endpackage : dsa_pkg

/* rtl/dsa_history_mem.sv */
// Sample history memory for one alarm channel.
// Assumes one write and one read per sample; read data is registered.
`timescale 1ns/1ps
`default_nettype none

module dsa_history_mem #(
   parameter int WIDTH = 16,
   parameter int ADDR_BITS = 8
) (
   // Clock and enable.
   input wire logic clk,
   input wire logic ce,
   // Write side.
   input wire logic wr_en,
   input wire logic [ADDR_BITS-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read side.
   input wire logic rd_en,
   input wire logic [ADDR_BITS-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   // Contents need no reset: the fill count hides stale words.
   logic [WIDTH-1:0] store [0:(1<<ADDR_BITS)-1];

   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         store[wr_addr] <= wr_data;
      end
      if (ce && rd_en) begin
         rd_data <= store[rd_addr];
      end
   end

endmodule : dsa_history_mem

`default_nettype wire

/* rtl/dsa_indicator.sv */
// Alarm indicator driver onto one of two digital lines.
// Assumes the line owner combines these enables with its own drivers.
`timescale 1ns/1ps
`default_nettype none

module dsa_indicator (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control.
   input wire logic alarm_any,
   input wire logic enable,
   input wire logic active_high,
   input wire logic use_line_two,
   // Digital lines, enables active low.
   output logic line_one_out,
   output logic line_one_oe_n,
   output logic line_two_out,
   output logic line_two_oe_n
);

   logic next_line_one_out;
   logic next_line_one_oe_n;
   logic next_line_two_out;
   logic next_line_two_oe_n;
   logic level;

   always_comb begin
      level = active_high ? alarm_any : ~alarm_any;
      next_line_one_out = 1'b0;
      next_line_two_out = 1'b0;
      next_line_one_oe_n = 1'b1;
      next_line_two_oe_n = 1'b1;
      if (enable) begin
         if (use_line_two) begin
            next_line_two_out = level;
            next_line_two_oe_n = 1'b0;
         end else begin
            next_line_one_out = level;
            next_line_one_oe_n = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         line_one_out <= 1'b0;
         line_one_oe_n <= 1'b1;
         line_two_out <= 1'b0;
         line_two_oe_n <= 1'b1;
      end else if (ce) begin
         line_one_out <= next_line_one_out;
         line_one_oe_n <= next_line_one_oe_n;
         line_two_out <= next_line_two_out;
         line_two_oe_n <= next_line_two_oe_n;
      end
   end

endmodule : dsa_indicator

`default_nettype wire

/* rtl/dsa_alarm_monitor.sv */
// Two alarm channels watching sensor outputs, with their registers and indicator.
// Assumes sample_strobe is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module dsa_alarm_monitor #(
   parameter int DATA_W = dsa_pkg::DATA_W,
   parameter int WINDOW_W = dsa_pkg::WINDOW_W
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register port.
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [dsa_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // Sample timing.
   input wire logic sample_strobe,
   // Unfiltered sensor outputs.
   input wire logic [DATA_W-1:0] rate_x_output,
   input wire logic [DATA_W-1:0] rate_y_output,
   input wire logic [DATA_W-1:0] rate_z_output,
   input wire logic [DATA_W-1:0] accel_x_output,
   input wire logic [DATA_W-1:0] accel_y_output,
   input wire logic [DATA_W-1:0] accel_z_output,
   input wire logic [DATA_W-1:0] temp_output,
   // Filtered sensor outputs.
   input wire logic [DATA_W-1:0] rate_x_filtered,
   input wire logic [DATA_W-1:0] rate_y_filtered,
   input wire logic [DATA_W-1:0] rate_z_filtered,
   input wire logic [DATA_W-1:0] accel_x_filtered,
   input wire logic [DATA_W-1:0] accel_y_filtered,
   input wire logic [DATA_W-1:0] accel_z_filtered,
   input wire logic [DATA_W-1:0] temp_filtered,
   // Alarm flags for the diagnostic status owner.
   output logic [1:0] alarm_flags,
   // Digital lines, enables active low.
   output logic digital_line_one_out,
   output logic digital_line_one_oe_n,
   output logic digital_line_two_out,
   output logic digital_line_two_oe_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Valid source codes; anything else, including off, never alarms.
   function automatic logic source_valid(input logic [3:0] code);
      logic ok;
      ok = 1'b0;
      case (code)
         dsa_pkg::SRC_RATE_X, dsa_pkg::SRC_RATE_Y, dsa_pkg::SRC_RATE_Z,
         dsa_pkg::SRC_ACCEL_X, dsa_pkg::SRC_ACCEL_Y, dsa_pkg::SRC_ACCEL_Z,
         dsa_pkg::SRC_TEMP: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : source_valid

   function automatic logic [DATA_W-1:0] source_pick(input logic [3:0] code,
                                                    input logic [6:0][DATA_W-1:0] set);
      logic [DATA_W-1:0] v;
      v = '0;
      case (code)
         dsa_pkg::SRC_RATE_X: v = set[0];
         dsa_pkg::SRC_RATE_Y: v = set[1];
         dsa_pkg::SRC_RATE_Z: v = set[2];
         dsa_pkg::SRC_ACCEL_X: v = set[3];
         dsa_pkg::SRC_ACCEL_Y: v = set[4];
         dsa_pkg::SRC_ACCEL_Z: v = set[5];
         dsa_pkg::SRC_TEMP: v = set[6];
         default: v = '0;
      endcase
      return v;
   endfunction : source_pick

   // Signed comparison by polarity; both sides are sign extended by one bit.
   function automatic logic trips(input logic signed [DATA_W:0] value,
                                  input logic signed [DATA_W:0] limit,
                                  input logic above);
      return above ? (value > limit) : (value < limit);
   endfunction : trips

   function automatic logic [WINDOW_W-1:0] window_len(input logic [WINDOW_W-1:0] w);
      return (w < dsa_pkg::MIN_WINDOW) ? dsa_pkg::MIN_WINDOW : w;
   endfunction : window_len

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   logic [15:0] alarm_configuration;
   logic [1:0][15:0] threshold;
   logic [1:0][WINDOW_W-1:0] window;
   logic [15:0] next_alarm_configuration;
   logic [1:0][15:0] next_threshold;
   logic [1:0][WINDOW_W-1:0] next_window;
   logic [15:0] next_reg_rdata;
   logic history_flush;
   logic [15:0] diagnostic_status;

   always_comb begin
      diagnostic_status = '0;
      diagnostic_status[dsa_pkg::DIAG_FLAG1_BIT] = alarm_flags[0];
      diagnostic_status[dsa_pkg::DIAG_FLAG2_BIT] = alarm_flags[1];
   end

   always_comb begin
      next_alarm_configuration = alarm_configuration;
      next_threshold = threshold;
      next_window = window;
      next_reg_rdata = reg_rdata;
      history_flush = 1'b0;
      if (reg_wr_en) begin
         if (reg_addr == dsa_pkg::OFS_CONFIGURATION) begin
            next_alarm_configuration = reg_wdata;
            history_flush = 1'b1;
         end else if (reg_addr == dsa_pkg::OFS_FIRST_THRESHOLD) begin
            next_threshold[0] = reg_wdata;
         end else if (reg_addr == dsa_pkg::OFS_SECOND_THRESHOLD) begin
            next_threshold[1] = reg_wdata;
         end else if (reg_addr == dsa_pkg::OFS_FIRST_WINDOW) begin
            next_window[0] = reg_wdata[WINDOW_W-1:0];
            history_flush = 1'b1;
         end else if (reg_addr == dsa_pkg::OFS_SECOND_WINDOW) begin
            next_window[1] = reg_wdata[WINDOW_W-1:0];
            history_flush = 1'b1;
         end
      end
      if (reg_rd_en) begin
         if (reg_addr == dsa_pkg::OFS_CONFIGURATION) begin
            next_reg_rdata = alarm_configuration;
         end else if (reg_addr == dsa_pkg::OFS_FIRST_THRESHOLD) begin
            next_reg_rdata = threshold[0];
         end else if (reg_addr == dsa_pkg::OFS_SECOND_THRESHOLD) begin
            next_reg_rdata = threshold[1];
         end else if (reg_addr == dsa_pkg::OFS_FIRST_WINDOW) begin
            next_reg_rdata = 16'(window[0]);
         end else if (reg_addr == dsa_pkg::OFS_SECOND_WINDOW) begin
            next_reg_rdata = 16'(window[1]);
         end else if (reg_addr == dsa_pkg::OFS_DIAGNOSTIC) begin
            next_reg_rdata = diagnostic_status;
         end else begin
            next_reg_rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alarm_configuration <= dsa_pkg::CONFIG_RESET;
         threshold <= {dsa_pkg::THRESHOLD_RESET, dsa_pkg::THRESHOLD_RESET};
         window <= {dsa_pkg::WINDOW_RESET, dsa_pkg::WINDOW_RESET};
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         alarm_configuration <= next_alarm_configuration;
         threshold <= next_threshold;
         window <= next_window;
         reg_rdata <= next_reg_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration decode.

   logic [1:0][3:0] source_code;
   logic [1:0] dynamic_mode;
   logic [1:0] above_mode;
   logic use_filtered;
   logic [6:0][DATA_W-1:0] raw_set;
   logic [6:0][DATA_W-1:0] filt_set;
   logic [1:0][DATA_W-1:0] selected;

   always_comb begin
      source_code[1] = alarm_configuration[dsa_pkg::SRC2_HI:dsa_pkg::SRC2_LO];
      source_code[0] = alarm_configuration[dsa_pkg::SRC1_HI:dsa_pkg::SRC1_LO];
      dynamic_mode[1] = alarm_configuration[dsa_pkg::DYN2_BIT];
      dynamic_mode[0] = alarm_configuration[dsa_pkg::DYN1_BIT];
      above_mode[1] = alarm_configuration[dsa_pkg::POL2_BIT];
      above_mode[0] = alarm_configuration[dsa_pkg::POL1_BIT];
      use_filtered = alarm_configuration[dsa_pkg::FILT_BIT];
      raw_set = {temp_output, accel_z_output, accel_y_output, accel_x_output,
                 rate_z_output, rate_y_output, rate_x_output};
      filt_set = {temp_filtered, accel_z_filtered, accel_y_filtered, accel_x_filtered,
                  rate_z_filtered, rate_y_filtered, rate_x_filtered};
      for (int i = 0; i < 2; i++) begin
         selected[i] = source_pick(source_code[i], use_filtered ? filt_set : raw_set);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample sequencing and evaluation.

   dsa_pkg::dsa_state_type state;
   dsa_pkg::dsa_state_type next_state;
   logic [WINDOW_W-1:0] write_ptr;
   logic [WINDOW_W-1:0] next_write_ptr;
   logic [1:0][WINDOW_W-1:0] fill;
   logic [1:0][WINDOW_W-1:0] next_fill;
   logic [1:0][DATA_W-1:0] current;
   logic [1:0][DATA_W-1:0] next_current;
   logic [1:0][WINDOW_W-1:0] fill_at_sample;
   logic [1:0][WINDOW_W-1:0] next_fill_at_sample;
   logic [1:0] next_alarm_flags;
   logic [1:0][WINDOW_W-1:0] read_addr;
   logic [1:0][DATA_W-1:0] past;
   logic mem_access;
   logic signed [DATA_W:0] delta;

   always_comb begin
      next_state = state;
      next_write_ptr = write_ptr;
      next_fill = fill;
      next_current = current;
      next_fill_at_sample = fill_at_sample;
      next_alarm_flags = alarm_flags;
      mem_access = 1'b0;
      delta = '0;
      for (int i = 0; i < 2; i++) begin
         read_addr[i] = write_ptr - window_len(window[i]);
      end
      case (state)
         dsa_pkg::ST_IDLE: begin
            if (sample_strobe) begin
               mem_access = 1'b1;
               next_current = selected;
               next_fill_at_sample = fill;
               next_write_ptr = write_ptr + 1'b1;
               for (int i = 0; i < 2; i++) begin
                  if (fill[i] != dsa_pkg::FILL_MAX) begin
                     next_fill[i] = fill[i] + 1'b1;
                  end
               end
               next_state = dsa_pkg::ST_EVAL;
            end
         end
         dsa_pkg::ST_EVAL: begin
            for (int i = 0; i < 2; i++) begin
               if (dynamic_mode[i]) begin
                  // No verdict until the window holds enough history.
                  delta = {current[i][DATA_W-1], current[i]} - {past[i][DATA_W-1], past[i]};
                  next_alarm_flags[i] = (fill_at_sample[i] >= window_len(window[i])) &&
                                        trips(delta, {threshold[i][15], threshold[i]},
                                              above_mode[i]);
               end else begin
                  next_alarm_flags[i] = trips({current[i][DATA_W-1], current[i]},
                                              {threshold[i][15], threshold[i]},
                                              above_mode[i]);
               end
            end
            next_state = dsa_pkg::ST_IDLE;
         end
         default: next_state = dsa_pkg::ST_IDLE;
      endcase
      // Reprogramming source or window makes the stored history meaningless.
      if (history_flush) begin
         next_fill = '0;
      end
      for (int i = 0; i < 2; i++) begin
         if (!source_valid(source_code[i])) begin
            next_alarm_flags[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= dsa_pkg::ST_IDLE;
         write_ptr <= '0;
         fill <= '0;
         current <= '0;
         fill_at_sample <= '0;
         alarm_flags <= 2'b00;
      end else if (ce) begin
         state <= next_state;
         write_ptr <= next_write_ptr;
         fill <= next_fill;
         current <= next_current;
         fill_at_sample <= next_fill_at_sample;
         alarm_flags <= next_alarm_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // History memories, one per channel.

   for (genvar g = 0; g < 2; g++) begin : gen_history
      dsa_history_mem #(
         .WIDTH(DATA_W),
         .ADDR_BITS(WINDOW_W)
      ) u_history (
         .clk(clk),
         .ce(ce),
         .wr_en(mem_access),
         .wr_addr(write_ptr),
         .wr_data(selected[g]),
         .rd_en(mem_access),
         .rd_addr(read_addr[g]),
         .rd_data(past[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indicator.

   dsa_indicator u_indicator (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .alarm_any(|alarm_flags),
      .enable(alarm_configuration[dsa_pkg::IND_EN_BIT]),
      .active_high(alarm_configuration[dsa_pkg::IND_POL_BIT]),
      .use_line_two(alarm_configuration[dsa_pkg::IND_SEL_BIT]),
      .line_one_out(digital_line_one_out),
      .line_one_oe_n(digital_line_one_oe_n),
      .line_two_out(digital_line_two_out),
      .line_two_oe_n(digital_line_two_oe_n)
   );

endmodule : dsa_alarm_monitor

`default_nettype wire

/* testbench/dsa_host_model.sv */
// Host side model: issues register writes and reads on the block's register port.
// Assumes the bench calls its tasks from one process; requests change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module dsa_host_model (
   // Clock.
   input wire logic clk,
   // Register port.
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [dsa_pkg::ADDR_W-1:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 16'h0000;
   end

   // Released lines show the inverse value so a late sample cannot pass by luck.
   task automatic write(input logic [6:0] addr, input logic [15:0] data);
      @(negedge clk);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
      reg_addr = ~addr;
      reg_wdata = ~data;
   endtask : write

   task automatic read(input logic [6:0] addr, output logic [15:0] data);
      @(negedge clk);
      reg_addr = addr;
      reg_rd_en = 1'b1;
      @(negedge clk);
      reg_rd_en = 1'b0;
      reg_addr = ~addr;
      data = reg_rdata;
   endtask : read
endmodule : dsa_host_model
`default_nettype wire

/* testbench/dsa_alarm_monitor_asserts.sv */
// Checker for the alarm monitor, bound to its top module.
// Assumes configuration writes are seen only through the register port.
`timescale 1ns/1ps
`default_nettype none

module dsa_alarm_checker #(
   parameter int DATA_W = 16,
   parameter int WINDOW_W = 8
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register port.
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [dsa_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   // Sampling and results.
   input wire logic sample_strobe,
   input wire logic [1:0] alarm_flags,
   input wire logic digital_line_one_out,
   input wire logic digital_line_one_oe_n,
   input wire logic digital_line_two_out,
   input wire logic digital_line_two_oe_n
);
   logic [15:0] shadow;
   logic [15:0] next_shadow;
   logic cfg_rd;
   logic diag_rd;

   ////////////////////////////////////////////////////////////////////////////////
   // A shadow of the configuration lets the indicator be judged without seeing inside.
   assign cfg_rd = ce && reg_rd_en && reg_addr == dsa_pkg::OFS_CONFIGURATION;
   assign diag_rd = ce && reg_rd_en && reg_addr == dsa_pkg::OFS_DIAGNOSTIC;
   always_comb begin
      next_shadow = shadow;
      if (rst) begin
         next_shadow = 16'h0000;
      end else if (ce && reg_wr_en && reg_addr == dsa_pkg::OFS_CONFIGURATION) begin
         next_shadow = reg_wdata;
      end
   end
   always_ff @(posedge clk) begin
      shadow <= next_shadow;
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   flag_change_cause_a: assert property ($changed(alarm_flags) |-> $past(sample_strobe, 2)
      || $past(reg_wr_en) || $past(reg_wr_en, 2) || $past(reg_wr_en, 3))
      else $error("alarm flags changed with no sample or write");
   ind_disable_a: assert property ($past(ce) && !$past(shadow[2]) |-> digital_line_one_oe_n
      && digital_line_two_oe_n && !digital_line_one_out && !digital_line_two_out)
      else $error("indicator drives a line while disabled");
   ind_route_a: assert property ($past(ce) && $past(shadow[2]) |->
      digital_line_one_oe_n == $past(shadow[0]) && digital_line_two_oe_n == !$past(shadow[0]))
      else $error("indicator on the wrong line");
   ind_level_a: assert property ($past(ce) && $past(shadow[2]) |->
      (digital_line_one_out | digital_line_two_out) ==
      ($past(shadow[1]) ? |$past(alarm_flags) : !(|$past(alarm_flags))))
      else $error("indicator level wrong");
   src_one_off_a: assert property ($past(shadow[11:8]) == 4'h0 && $past(shadow[11:8], 2) == 4'h0
      && $past(shadow[11:8], 3) == 4'h0 |-> !alarm_flags[0])
      else $error("first alarm active with no source");
   src_two_off_a: assert property ($past(shadow[15:12]) == 4'h0
      && $past(shadow[15:12], 2) == 4'h0 && $past(shadow[15:12], 3) == 4'h0 |-> !alarm_flags[1])
      else $error("second alarm active with no source");
   cfg_read_a: assert property ($past(cfg_rd) |-> reg_rdata == $past(shadow))
      else $error("configuration read back wrong");
   diag_read_a: assert property ($past(diag_rd) |->
      reg_rdata == {6'h00, $past(alarm_flags), 8'h00})
      else $error("status read does not show alarm flags");
   rdata_hold_a: assert property (!$past(reg_rd_en) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule : dsa_alarm_checker

bind dsa_alarm_monitor dsa_alarm_checker #(.DATA_W(DATA_W), .WINDOW_W(WINDOW_W)) u_checker (
   .clk(clk), .rst(rst), .ce(ce), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .sample_strobe(sample_strobe), .alarm_flags(alarm_flags),
   .digital_line_one_out(digital_line_one_out), .digital_line_one_oe_n(digital_line_one_oe_n),
   .digital_line_two_out(digital_line_two_out), .digital_line_two_oe_n(digital_line_two_oe_n));
`default_nettype wire

/* testbench/dsa_alarm_monitor_tb.sv */
// Self-checking bench for the alarm monitor with a host model on the register port.
// Assumes the checker is bound to the design; sensor data is random from a fixed seed.
`timescale 1ns/1ps
`default_nettype none

module dsa_alarm_monitor_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic sample_strobe = 1'b0;
   logic [15:0] raw [7];
   logic [15:0] filt [7];
   logic reg_wr_en, reg_rd_en, l1, l1n, l2, l2n;
   logic [6:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd, r, cfg;
   logic [1:0] alarm_flags, f;
   logic [15:0] thr [2];
   logic [7:0] win [2];
   logic [15:0] hist [2][$];
   logic [31:0] seed = 32'h5B142DAA;
   logic [7:0] wins [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
   logic [6:0] offs [7] = '{7'h40, 7'h42, 7'h44, 7'h46, 7'h48, 7'h3C, 7'h50};
   int num_errors = 0;
   int n_compared = 0;

   always #25 clk = ~clk;

   dsa_host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   dsa_alarm_monitor dut (.clk(clk), .rst(rst), .ce(ce), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_strobe(sample_strobe), .rate_x_output(raw[0]), .rate_y_output(raw[1]),
      .rate_z_output(raw[2]), .accel_x_output(raw[3]), .accel_y_output(raw[4]),
      .accel_z_output(raw[5]), .temp_output(raw[6]), .rate_x_filtered(filt[0]),
      .rate_y_filtered(filt[1]), .rate_z_filtered(filt[2]), .accel_x_filtered(filt[3]),
      .accel_y_filtered(filt[4]), .accel_z_filtered(filt[5]), .temp_filtered(filt[6]),
      .alarm_flags(alarm_flags), .digital_line_one_out(l1), .digital_line_one_oe_n(l1n),
      .digital_line_two_out(l2), .digital_line_two_oe_n(l2n));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] r16();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[31:16];
   endfunction : r16

   function automatic logic [15:0] pick(input logic [3:0] src);
      logic [2:0] k;
      k = (src == 4'hC) ? 3'h6 : 3'(src - 4'h1);
      return cfg[3] ? filt[k] : raw[k];
   endfunction : pick

   function automatic logic [3:0] exp_lines(input logic [15:0] c, input logic [1:0] fl);
      logic lvl;
      lvl = c[1] ? |fl : ~|fl;
      if (!c[2]) return 4'h5;
      return c[0] ? {lvl, 3'h1} : {2'h1, lvl, 1'b0};
   endfunction : exp_lines

   // Dynamic mode stays quiet until the window is full, as history restarts on a configuration or window write.
   function automatic logic model(input int ch);
      logic [3:0] src;
      logic [15:0] v, h;
      logic signed [16:0] d, t;
      logic ok;
      int n;
      src = ch ? cfg[15:12] : cfg[11:8];
      n = (win[ch] < 8'h02) ? 1 : int'(win[ch]);
      v = pick(src);
      t = {thr[ch][15], thr[ch]};
      d = {v[15], v};
      ok = src inside {[4'h1:4'h6], 4'hC};
      if (cfg[6 + ch]) begin
         ok = ok && hist[ch].size() >= n;
         if (ok) begin
            h = hist[ch][hist[ch].size() - n];
            d = d - {h[15], h};
         end
      end
      ok = ok && (cfg[4 + ch] ? d > t : d < t);
      hist[ch].push_back(v);
      return ok;
   endfunction : model

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      close_out();
   end

   initial begin
      for (int j = 0; j < 7; j++) begin
         raw[j] = 16'h0000;
         filt[j] = 16'h0000;
      end
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      host.write(7'h50, 16'hFFFF);
      foreach (offs[i]) begin
         host.read(offs[i], rd);
         check(rd, 16'h0000);
      end
      host.write(7'h44, 16'hFFFF);
      host.read(7'h44, rd);
      check(rd, 16'h00FF);
      @(negedge clk) ce = 1'b0;
      host.write(7'h48, 16'h36AF);
      ce = 1'b1;
      host.read(7'h48, rd);
      check(rd, 16'h0000);
      for (int i = 0; i < 32; i++) begin
         r = r16();
         cfg = {4'(i), 4'((i * 7 + 3) % 16), r[7:0]};
         for (int c = 0; c < 2; c++) begin
            thr[c] = r16();
            r = r16();
            win[c] = wins[r[2:0] % 3'h5];
            host.write(7'h40 + 7'(2 * c), thr[c]);
            host.write(7'h44 + 7'(2 * c), {8'h00, win[c]});
            hist[c].delete();
         end
         host.write(7'h48, cfg);
         host.read(7'h48, rd);
         check(rd, cfg);
         for (int k = 0; k < 10; k++) begin
            @(negedge clk);
            for (int j = 0; j < 7; j++) begin
               raw[j] = r16();
               filt[j] = r16();
            end
            sample_strobe = 1'b1;
            f = {model(1), model(0)};
            @(negedge clk);
            sample_strobe = 1'b0;
            raw[0] = ~raw[0];
            filt[0] = ~filt[0];
            @(negedge clk);
            check({14'h0000, alarm_flags}, {14'h0000, f});
            @(negedge clk);
            check({12'h000, l2, l2n, l1, l1n}, {12'h000, exp_lines(cfg, f)});
         end
         host.read(7'h3C, rd);
         check(rd, {6'h00, f, 8'h00});
      end
      close_out();
   end
endmodule : dsa_alarm_monitor_tb
`default_nettype wire
